// ===== design/tcm_mode_irq.sv
`timescale 1ns/100ps
// Purpose: Six channel modules with mode control, two counters, one interrupt
// Assumes: Pin inputs synchronous to clock; software owns the register port
// Notes:   Capture words and the read data flop sit in tcm_capture_mem; all else is flops here
module tcm_mode_irq
    import tcm_pkg::*;
(
    // Clock, reset, enable
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic         clock_en,
    // Register port
    input  wire logic [5:0]   addr,
    input  wire logic [7:0]   wr_data,
    input  wire logic         wr_stb,
    input  wire logic         rd_stb,
    output logic      [7:0]   rd_data,
    // Channel module pins
    input  wire logic [5:0]   module_io_pin_in,
    output logic      [5:0]   module_io_pin_out,
    output logic      [5:0]   module_io_pin_oe_n,
    // Interrupt
    output logic              irq
);

    // =====================================================
    // State
    logic [5:0][7:0]   mode;
    logic [5:0][15:0]  compare;
    logic [5:0][7:0]   prog_div;
    logic [1:0][7:0]   ctrl;
    logic [1:0][15:0]  count;
    logic [1:0]        count_moved;
    logic [7:0]        status;
    logic [7:0]        mask;
    logic [5:0]        pin_prev;
    logic [5:0]        pin_q;
    logic [5:0]        oe_n_q;
    logic              irq_q;

    tcm_mem_if mem_bus ();

    // =====================================================
    // Address decode
    wire       mode_hit   = addr < 6'(ADDR_MODE0 + 6'(NUM_MOD));
    wire [2:0] mode_idx   = addr[2:0];
    wire       cmp_hit    = tcm_in_pairs(addr, ADDR_CMP_BASE);
    wire [5:0] cmp_off    = 6'(addr - ADDR_CMP_BASE);
    wire       cap_hit    = tcm_in_pairs(addr, ADDR_CAP_BASE);
    wire [5:0] cap_off    = 6'(addr - ADDR_CAP_BASE);
    wire       cnt_hit    = (addr >= ADDR_CNT_BASE) && (addr < 6'(ADDR_CNT_BASE + 6'h04));
    wire [5:0] cnt_off    = 6'(addr - ADDR_CNT_BASE);
    wire       wr_mode    = wr_stb && mode_hit;
    wire       wr_cmp     = wr_stb && cmp_hit;
    wire       wr_status  = wr_stb && (addr == ADDR_STATUS);
    wire       wr_mask    = wr_stb && (addr == ADDR_MASK);
    wire       wr_ctrl0   = wr_stb && (addr == ADDR_CTRL0);
    wire       wr_ctrl1   = wr_stb && (addr == ADDR_CTRL1);
    wire [7:0] status_clr = wr_status ? wr_data : 8'h00;

    // =====================================================
    // Counters: modules 0-2 follow counter 0, modules 3-5 counter 1
    logic [1:0]        cnt_run;
    logic [1:0]        cnt_ovf;
    logic [1:0][15:0]  next_count;

    always_comb
    begin
        for (int k = 0; k < 2; k++)
        begin
            cnt_run[k]    = ctrl[k][CTRL_RUN_BIT];
            cnt_ovf[k]    = cnt_run[k] && (count[k] == 16'hffff);
            next_count[k] = cnt_run[k] ? 16'(count[k] + 16'h0001) : count[k];
        end
    end

    // =====================================================
    // Channel module behaviour
    logic [5:0]        rise;
    logic [5:0]        fall;
    logic [5:0]        capture;
    logic [5:0]        match;
    logic [5:0]        pwm_hi;
    logic [5:0]        next_pin;
    logic [5:0]        next_oe_n;
    logic [5:0][7:0]   next_prog_div;
    logic [5:0][15:0]  cap_word;
    logic [7:0]        flag_set;
    logic [7:0]        irq_gate;

    always_comb
    begin
        flag_set = 8'h00;
        irq_gate = 8'h00;
        for (int i = 0; i < NUM_MOD; i++)
        begin
            logic [15:0] cnt;
            logic        moved;
            logic        wide10;
            tcm_pwm_e    pwm;
            cnt     = count[i / 3];
            moved   = count_moved[i / 3];
            wide10  = ctrl[i / 3][CTRL_PWM_WIDE_BIT];
            pwm     = tcm_pwm_e'(mode[i][1:0]);
            rise[i] = module_io_pin_in[i] && !pin_prev[i];
            fall[i] = !module_io_pin_in[i] && pin_prev[i];
            cap_word[i] = cnt;
            capture[i]  = (mode[i][MODE_CAP_RISE_BIT] && rise[i])
                       || (mode[i][MODE_CAP_FALL_BIT] && fall[i]);
            // Match counts only once per counter step, not while stopped
            match[i] = mode[i][MODE_COMP_EN_BIT] && moved
                    && (cnt == compare[i]) && (pwm == PWM_OFF);
            if (match[i] || capture[i])
                flag_set[tcm_flag_pos(i)] = capture[i]
                                         || mode[i][MODE_MATCH_BIT];
            irq_gate[tcm_flag_pos(i)] = mode[i][MODE_IRQ_EN_BIT];

            // Programmable frequency: private divider wraps at compare high byte
            next_prog_div[i] = prog_div[i];
            if (moved)
                next_prog_div[i] = (prog_div[i] >= compare[i][15:8]) ? 8'h00
                                 : 8'(prog_div[i] + 8'h01);

            case (pwm)
                PWM_8FIX:  pwm_hi[i] = cnt[7:0] < compare[i][7:0];
                PWM_8PROG: pwm_hi[i] = prog_div[i] < compare[i][7:0];
                PWM_WIDE:  pwm_hi[i] = wide10 ? (cnt[9:0] < compare[i][9:0])
                                              : (cnt < compare[i]);
                default:   pwm_hi[i] = 1'b0;
            endcase

            // Pin holds its level unless toggling or a live PWM drives it
            if (pwm != PWM_OFF)
                next_pin[i] = mode[i][MODE_COMP_EN_BIT] ? pwm_hi[i] : pin_q[i];
            else
                next_pin[i] = pin_q[i] ^ (match[i] && mode[i][MODE_TOGGLE_BIT]);
            next_oe_n[i] = !((pwm != PWM_OFF) || mode[i][MODE_TOGGLE_BIT]);
        end
        flag_set[STAT_OVF0_BIT] = cnt_ovf[0];
        flag_set[STAT_OVF1_BIT] = cnt_ovf[1];
        irq_gate[STAT_OVF0_BIT] = ctrl[0][CTRL_OVF_IRQ_BIT];
        irq_gate[STAT_OVF1_BIT] = ctrl[1][CTRL_OVF_IRQ_BIT];
    end

    // =====================================================
    // Status and interrupt
    // Set beats a write-one clear landing in the same cycle
    wire [7:0] next_status = (status & ~status_clr) | flag_set;
    wire       next_irq    = |(status & mask & irq_gate);

    // =====================================================
    // Readback byte for everything but capture words
    logic [7:0] read_byte;

    always_comb
    begin
        read_byte = 8'h00;
        if (mode_hit)
            read_byte = mode[mode_idx];
        else if (addr == ADDR_STATUS)
            read_byte = status;
        else if (addr == ADDR_MASK)
            read_byte = mask;
        else if (addr == ADDR_CTRL0)
            read_byte = ctrl[0];
        else if (addr == ADDR_CTRL1)
            read_byte = ctrl[1];
        else if (cnt_hit)
            read_byte = cnt_off[0] ? count[cnt_off[1]][15:8] : count[cnt_off[1]][7:0];
        else if (cmp_hit)
            read_byte = cmp_off[0] ? compare[cmp_off[3:1]][15:8] : compare[cmp_off[3:1]][7:0];
    end

    // =====================================================
    // Capture memory
    assign mem_bus.en      = clock_en;
    assign mem_bus.we      = capture;
    assign mem_bus.wdata   = cap_word;
    assign mem_bus.rd_stb  = rd_stb;
    assign mem_bus.cap_sel = cap_hit;
    assign mem_bus.cap_idx = cap_off[3:1];
    assign mem_bus.cap_hi  = cap_off[0];
    assign mem_bus.bypass  = read_byte;

    tcm_capture_mem u_mem (
        .clock (clock),
        .rst_n (rst_n),
        .port  (mem_bus.mem)
    );

    // =====================================================
    // Software registers
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode <= {NUM_MOD{MODE_RESET}};
            mask <= MASK_RESET;
            ctrl <= {2{CTRL_RESET}};
        end
        else if (clock_en)
        begin
            if (wr_mode)
                mode[mode_idx] <= wr_data;
            if (wr_mask)
                mask <= wr_data;
            if (wr_ctrl0)
                ctrl[0] <= wr_data;
            if (wr_ctrl1)
                ctrl[1] <= wr_data;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            compare <= '0;
        else if (clock_en && wr_cmp)
        begin
            if (cmp_off[0])
                compare[cmp_off[3:1]][15:8] <= wr_data;
            else
                compare[cmp_off[3:1]][7:0] <= wr_data;
        end
    end

    // =====================================================
    // Counters and per-module state
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count       <= '0;
            count_moved <= 2'h0;
            prog_div    <= '0;
        end
        else if (clock_en)
        begin
            count       <= next_count;
            count_moved <= cnt_run;
            prog_div    <= next_prog_div;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status   <= STATUS_RESET;
            pin_prev <= 6'h00;
            pin_q    <= 6'h00;
            oe_n_q   <= 6'h3f;
            irq_q    <= 1'b0;
        end
        else if (clock_en)
        begin
            status   <= next_status;
            pin_prev <= module_io_pin_in;
            pin_q    <= next_pin;
            oe_n_q   <= next_oe_n;
            irq_q    <= next_irq;
        end
    end

    // =====================================================
    // Outputs, each straight from a flop
    assign rd_data            = mem_bus.rdata;
    assign module_io_pin_out  = pin_q;
    assign module_io_pin_oe_n = oe_n_q;
    assign irq                = irq_q;

endmodule

// ===== design/tcm_pkg.sv
// Purpose: Constants for the timer channel module mode and interrupt block
// Assumes: 8-bit register port, six channel modules, two counters
// Notes:   Modules 0-2 use counter 0, modules 3-5 use counter 1
package tcm_pkg;

    localparam int NUM_MOD = 6;
    localparam int ADDR_W  = 6;
    localparam int CNT_W   = 16;

    // =====================================================
    // Register offsets
    localparam logic [5:0] ADDR_MODE0    = 6'h00;
    localparam logic [5:0] ADDR_STATUS   = 6'h06;
    localparam logic [5:0] ADDR_MASK     = 6'h07;
    localparam logic [5:0] ADDR_CTRL0    = 6'h08;
    localparam logic [5:0] ADDR_CTRL1    = 6'h09;
    localparam logic [5:0] ADDR_CNT_BASE = 6'h0a;
    localparam logic [5:0] ADDR_CMP_BASE = 6'h10;
    localparam logic [5:0] ADDR_CAP_BASE = 6'h20;

    // =====================================================
    // Field positions
    localparam int MODE_IRQ_EN_BIT   = 7;
    localparam int MODE_COMP_EN_BIT  = 6;
    localparam int MODE_CAP_RISE_BIT = 5;
    localparam int MODE_CAP_FALL_BIT = 4;
    localparam int MODE_MATCH_BIT    = 3;
    localparam int MODE_TOGGLE_BIT   = 2;
    localparam int CTRL_RUN_BIT      = 6;
    localparam int CTRL_OVF_IRQ_BIT  = 5;
    localparam int CTRL_PWM_WIDE_BIT = 2;
    localparam int STAT_OVF0_BIT     = 3;
    localparam int STAT_OVF1_BIT     = 7;

    // =====================================================
    // Reset values
    localparam logic [7:0] MODE_RESET   = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET   = 8'hff;
    localparam logic [7:0] CTRL_RESET   = 8'h00;

    typedef enum logic [1:0] {
        PWM_OFF   = 2'h0,
        PWM_8FIX  = 2'h1,
        PWM_8PROG = 2'h2,
        PWM_WIDE  = 2'h3
    } tcm_pwm_e;

    // Status bit of a channel module: 0,1,2 then 4,5,6
    function automatic logic [2:0] tcm_flag_pos(input int idx);
        tcm_flag_pos = (idx < 3) ? 3'(idx) : 3'(idx + 1);
    endfunction

    // Address falls in a block of six lo/hi byte pairs
    function automatic logic tcm_in_pairs(input logic [5:0] a, input logic [5:0] base);
        tcm_in_pairs = (a >= base) && (a < 6'(base + 6'h0c));
    endfunction

endpackage

// ===== design/tcm_mem_if.sv
`timescale 1ns/100ps
// Purpose: Carrier between the control logic and the capture memory
// Assumes: One clock domain
// Notes:   Read result doubles as the register port read data
interface tcm_mem_if;
    logic             en;
    logic [5:0]       we;
    logic [5:0][15:0] wdata;
    logic             rd_stb;
    logic             cap_sel;
    logic [2:0]       cap_idx;
    logic             cap_hi;
    logic [7:0]       bypass;
    logic [7:0]       rdata;

    modport ctrl (output en, we, wdata, rd_stb, cap_sel, cap_idx, cap_hi, bypass, input rdata);
    modport mem  (input en, we, wdata, rd_stb, cap_sel, cap_idx, cap_hi, bypass, output rdata);
endinterface

// ===== design/tcm_capture_mem.sv
`timescale 1ns/100ps
// Purpose: Six 16-bit capture words with a registered read port
// Assumes: Writes from capture events only, one per word per cycle
// Notes:   Read register also carries the other register readback
module tcm_capture_mem
    import tcm_pkg::*;
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // Control side
    tcm_mem_if.mem    port
);

    logic [15:0] word [NUM_MOD];

    // =====================================================
    // Storage
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NUM_MOD; i++)
                word[i] <= 16'h0000;
        end
        else if (port.en)
        begin
            for (int i = 0; i < NUM_MOD; i++)
                if (port.we[i])
                    word[i] <= port.wdata[i];
        end
    end

    // =====================================================
    // Read port: data stand only in the cycle after the strobe
    wire [15:0] sel_word  = word[port.cap_idx];
    wire [7:0]  cap_byte  = port.cap_hi ? sel_word[15:8] : sel_word[7:0];
    wire [7:0]  next_read = !port.rd_stb ? 8'h00 : (port.cap_sel ? cap_byte : port.bypass);

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            port.rdata <= 8'h00;
        else if (port.en)
            port.rdata <= next_read;
    end

endmodule

// ===== verif/tcm_mode_irq_assertions.sv
// Purpose: Port-level checks of the mode and interrupt block
// Assumes: Bench keeps mode0, mask and status writes apart
// Notes:   Latencies are the design's registered ones
`timescale 1ns/100ps
module tcm_mode_irq_assertions
    import tcm_pkg::*;
(
    // Clock and reset
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       clock_en,
    // Register port
    input wire logic [5:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic       wr_stb,
    input wire logic       rd_stb,
    input wire logic [7:0] rd_data,
    // Pins and interrupt
    input wire logic [5:0] module_io_pin_in,
    input wire logic [5:0] module_io_pin_out,
    input wire logic [5:0] module_io_pin_oe_n,
    input wire logic       irq
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // ==========
    // Register port and reset
    a_rd_idle_zero: assert property (clock_en && !rd_stb |=> rd_data == 8'h00)
        else $error("read data not zero outside read answer");
    a_reset_quiet: assert property ($rose(rst_n) |-> !irq && module_io_pin_oe_n == 6'h3f)
        else $error("outputs not idle after reset");
    a_freeze_outputs: assert property (!clock_en |=> $stable(irq) && $stable(rd_data))
        else $error("outputs moved while frozen");

    // ==========
    // Pins
    a_mode_drives_pin: assert property (clock_en && wr_stb && addr == ADDR_MODE0 && wr_data[2:0] != 3'h0
        |-> ##[1:2] !module_io_pin_oe_n[0])
        else $error("pin not driven after toggle or pwm mode");
    a_oe_needs_write: assert property ($changed(module_io_pin_oe_n) |-> $past(wr_stb) || $past(wr_stb, 2))
        else $error("pin enable moved without a write");
    a_undriven_hold: assert property ((module_io_pin_oe_n & $past(module_io_pin_oe_n)
        & $past(module_io_pin_oe_n, 2) & (module_io_pin_out ^ $past(module_io_pin_out))) == 6'h00)
        else $error("undriven pin level changed");

    // ==========
    // Interrupt
    a_irq_fall_write: assert property ($fell(irq) |-> $past(wr_stb) || $past(wr_stb, 2))
        else $error("interrupt dropped without a write");
    a_mask_silences: assert property (clock_en && wr_stb && addr == ADDR_MASK && wr_data == 8'h00
        |-> ##2 !irq)
        else $error("interrupt high with all sources masked");
    a_clear_silences: assert property (clock_en && wr_stb && addr == ADDR_STATUS && wr_data == 8'hff
        |-> ##2 !irq)
        else $error("interrupt high after clearing all flags");
endmodule

bind tcm_mode_irq tcm_mode_irq_assertions u_chk (.clock(clock), .rst_n(rst_n), .clock_en(clock_en), .addr(addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .module_io_pin_in(module_io_pin_in),
    .module_io_pin_out(module_io_pin_out), .module_io_pin_oe_n(module_io_pin_oe_n), .irq(irq));

// ===== verif/tcm_mode_irq_tb.sv
// Purpose: Self-checking bench for the mode and interrupt block
// Assumes: Register map and registered latencies of the block
// Notes:   Waiting for a full counter wrap costs some 66k cycles
`timescale 1ns/100ps
module tcm_mode_irq_tb
    import tcm_pkg::*;
;
    logic       clock;
    logic       rst_n;
    logic       clock_en;
    logic [5:0] addr;
    logic [7:0] wr_data;
    logic       wr_stb;
    logic       rd_stb;
    logic [7:0] rd_data;
    logic [5:0] module_io_pin_in;
    logic [5:0] module_io_pin_out;
    logic [5:0] module_io_pin_oe_n;
    logic       irq;
    int         num_errors;
    int         cmp_count;
    int         hi;

    tcm_mode_irq u_dut (.clock(clock), .rst_n(rst_n), .clock_en(clock_en), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .module_io_pin_in(module_io_pin_in),
        .module_io_pin_out(module_io_pin_out), .module_io_pin_oe_n(module_io_pin_oe_n), .irq(irq));

    always #25 clock = ~clock;

    // ==========
    // Access tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clock);
        addr    <= a;
        wr_data <= d;
        wr_stb  <= 1'b1;
        @(posedge clock);
        wr_stb  <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        @(posedge clock);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        @(negedge clock);
        chk(rd_data, exp, "rd_data");
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask

    // Any whole period of the pwm holds the same high count
    task automatic duty(input int n, input int exp);
        hi = 0;
        repeat (n)
        begin
            @(negedge clock);
            if (module_io_pin_out[3] === 1'b1)
                hi++;
        end
        chk(16'(hi), 16'(exp), "duty");
    endtask

    task automatic summarize;
        $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ==========
    // Sequence
    initial
    begin
        clock = 1'b0;
        rst_n = 1'b0;
        clock_en = 1'b1;
        addr = 6'h00;
        wr_data = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        module_io_pin_in = 6'h00;
        num_errors = 0;
        cmp_count = 0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        @(negedge clock);
        chk(module_io_pin_oe_n, 16'h3f, "oe");
        for (int i = 0; i < 6; i++)
            rd(6'(i), MODE_RESET);
        rd(6'h3f, 8'h00);
        // Captures: rising only, falling only, both, both with irq
        wr(6'h00, 8'h20);
        wr(6'h01, 8'h10);
        wr(6'h03, 8'h30);
        wr(6'h04, 8'hb0);
        module_io_pin_in <= 6'h0b;
        tick(3);
        rd(ADDR_STATUS, 8'h11);
        chk(irq, 16'h0, "irq");
        wr(ADDR_STATUS, 8'hff);
        module_io_pin_in <= 6'h00;
        tick(3);
        rd(ADDR_STATUS, 8'h12);
        wr(ADDR_STATUS, 8'h02);
        rd(ADDR_STATUS, 8'h10);
        wr(ADDR_MASK, 8'h00);
        module_io_pin_in <= 6'h10;
        tick(3);
        chk(irq, 16'h0, "irq");
        rd(ADDR_STATUS, 8'h30);
        wr(ADDR_MASK, 8'hff);
        tick(2);
        chk(irq, 16'h1, "irq");
        // Frozen cycle swallows the clear
        @(posedge clock);
        clock_en <= 1'b0;
        wr(ADDR_STATUS, 8'h20);
        clock_en <= 1'b1;
        tick(2);
        chk(irq, 16'h1, "irq");
        wr(ADDR_STATUS, 8'h20);
        tick(2);
        chk(irq, 16'h0, "irq");
        rd(ADDR_STATUS, 8'h10);
        wr(ADDR_STATUS, 8'hff);
        // Match at count 5: toggle, software timer, comparator off
        wr(ADDR_CMP_BASE, 8'h05);
        wr(6'h12, 8'h05);
        wr(6'h14, 8'h05);
        wr(6'h01, 8'h48);
        wr(6'h02, 8'h0c);
        wr(6'h00, 8'h4c);
        wr(ADDR_CTRL0, 8'h40);
        tick(12);
        chk(module_io_pin_out[2:0], 16'h1, "pins");
        chk(module_io_pin_oe_n[2:0], 16'h2, "oe");
        rd(ADDR_STATUS, 8'h03);
        wr(ADDR_CTRL0, 8'h00);
        // Counter 0 stopped after fifteen steps; pin 2 rise captures it
        wr(6'h02, 8'h20);
        module_io_pin_in <= 6'h14;
        tick(3);
        rd(6'h24, 8'h0f);
        rd(6'h25, 8'h00);
        rd(ADDR_CNT_BASE, 8'h0f);
        rd(ADDR_STATUS, 8'h07);
        // Pwm codes drive the pin, then duty per width
        for (int c = 1; c < 4; c++)
        begin
            wr(6'h05, 8'h40 | 8'(c));
            tick(2);
            chk(module_io_pin_oe_n[5], 16'h0, "oe");
        end
        wr(6'h16, 8'h80);
        wr(6'h03, 8'h41);
        wr(ADDR_CTRL1, 8'h60);
        tick(4);
        duty(256, 128);
        wr(6'h16, 8'h00);
        wr(6'h17, 8'h01);
        wr(ADDR_CTRL1, 8'h64);
        wr(6'h03, 8'h43);
        tick(4);
        duty(1024, 256);
        wr(ADDR_CTRL1, 8'h60);
        tick(4);
        duty(1024, 0);
        // Programmable frequency: divider period four, high for two
        wr(6'h16, 8'h02);
        wr(6'h17, 8'h03);
        wr(6'h03, 8'h42);
        tick(4);
        duty(256, 128);
        // Counter wrap raises the overflow source
        wr(6'h03, 8'h00);
        wr(6'h05, 8'h00);
        wr(ADDR_STATUS, 8'hff);
        hi = 0;
        while (irq !== 1'b1 && hi < 70000)
        begin
            @(negedge clock);
            hi++;
        end
        if (hi >= 70000)
            num_errors++;
        else
        begin
            rd(ADDR_STATUS, 8'h80);
            wr(ADDR_STATUS, 8'h80);
            tick(2);
            chk(irq, 16'h0, "irq");
        end
        summarize();
    end
endmodule
